// File: srsp_params.svh
// Timing and encoding constants for the serial register slave port and its master
`ifndef SRSP_PARAMS_SVH
`define SRSP_PARAMS_SVH

`define SRSP_CLK_NS    20
`define SRSP_T_QTR_NS  1250
`define SRSP_QTR_CYC   ((`SRSP_T_QTR_NS + `SRSP_CLK_NS - 1) / `SRSP_CLK_NS)
`define SRSP_ACK_CNT   4'h8
`define SRSP_WP_PTR    2'h0
`define SRSP_WP_HI     2'h1
`define SRSP_WP_LO     2'h2
`define SRSP_RST_BYTE  8'h00
`define SRSP_RST_WORD  16'h0000

`endif

// File: srsp_pkg.sv
// Types shared by both ends of the serial register port
package srsp_pkg;

   typedef enum logic [1:0] {
      SRSP_START,
      SRSP_STOP,
      SRSP_WRITE,
      SRSP_READ
   } srsp_kind_t;

   typedef enum logic [2:0] {
      SRSP_D_IDLE,
      SRSP_D_ADDR,
      SRSP_D_ADDR_ACK,
      SRSP_D_WR_BYTE,
      SRSP_D_WR_ACK,
      SRSP_D_RD_BYTE,
      SRSP_D_RD_ACK,
      SRSP_D_RD_LOAD
   } srsp_dstate_t;

   typedef enum logic {
      SRSP_M_IDLE,
      SRSP_M_RUN
   } srsp_mstate_t;

endpackage : srsp_pkg

// File: srsp_if.sv
// Two-wire bus carrier joining the master end and the device end
interface srsp_if;
   logic scl_o_m;
   logic scl_oe_m;
   logic sda_o_m;
   logic sda_oe_m;
   logic sda_o_d;
   logic sda_oe_d;
   logic scl;
   logic sda;

   // Open drain: a driven line is low, a released line floats high
   assign scl = ~(scl_oe_m & ~scl_o_m);
   assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_d & ~sda_o_d));

   modport dev (input scl, input sda, output sda_o_d, output sda_oe_d);
   modport mst (input sda, output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m);
endinterface : srsp_if

// File: srsp_device.sv
// Device end: two-wire register slave with pointer latch and word transfers
`include "srsp_params.svh"

module srsp_device (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Two-wire bus
   srsp_if.dev              bus,
   // Configuration
   input  wire logic [6:0]  own_addr,
   // Register file side
   output logic             wr_stb,
   output logic [15:0]      wr_data,
   output logic [7:0]       reg_ptr,
   input  wire logic [15:0] rd_data
);
   import srsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchroniser and deglitch filter

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [2:0] scl_hist;
   logic [2:0] sda_hist;
   logic       scl_f;
   logic       sda_f;
   logic       scl_p;
   logic       sda_p;
   logic [1:0] next_scl_sync;
   logic [1:0] next_sda_sync;
   logic [2:0] next_scl_hist;
   logic [2:0] next_sda_hist;
   logic       next_scl_f;
   logic       next_sda_f;

   always_comb begin
      next_scl_sync = {scl_sync[0], bus.scl};
      next_sda_sync = {sda_sync[0], bus.sda};
      next_scl_hist = {scl_hist[1:0], scl_sync[1]};
      next_sda_hist = {sda_hist[1:0], sda_sync[1]};
      // A level is taken only after three equal samples, so a one or two cycle
      // spike never reaches the edge and condition detectors
      next_scl_f = scl_f;
      next_sda_f = sda_f;
      if (&scl_hist) begin
         next_scl_f = 1'b1;
      end else if (~|scl_hist) begin
         next_scl_f = 1'b0;
      end
      if (&sda_hist) begin
         next_sda_f = 1'b1;
      end else if (~|sda_hist) begin
         next_sda_f = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_hist <= 3'h7;
         sda_hist <= 3'h7;
         scl_f    <= 1'b1;
         sda_f    <= 1'b1;
         scl_p    <= 1'b1;
         sda_p    <= 1'b1;
      end else begin
         scl_sync <= next_scl_sync;
         sda_sync <= next_sda_sync;
         scl_hist <= next_scl_hist;
         sda_hist <= next_sda_hist;
         scl_f    <= next_scl_f;
         sda_f    <= next_sda_f;
         scl_p    <= scl_f;
         sda_p    <= sda_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus events

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   assign scl_rise   = scl_f & ~scl_p;
   assign scl_fall   = ~scl_f & scl_p;
   // Both lines pass the same filter, so their relative order is kept
   assign start_seen = scl_f & scl_p & sda_p & ~sda_f;
   assign stop_seen  = scl_f & scl_p & ~sda_p & sda_f;

   ////////////////////////////////////////////////////////////////////////////////
   // Transfer state machine

   srsp_dstate_t state;
   srsp_dstate_t next_state;
   logic [3:0]   bitcnt;
   logic [3:0]   next_bitcnt;
   logic [7:0]   shreg;
   logic [7:0]   next_shreg;
   logic         dir;
   logic         next_dir;
   logic [1:0]   wphase;
   logic [1:0]   next_wphase;
   logic [7:0]   next_reg_ptr;
   logic [7:0]   hi;
   logic [7:0]   next_hi;
   logic         rd_half;
   logic         next_rd_half;
   logic         sda_oe;
   logic         next_sda_oe;
   logic         next_wr_stb;
   logic [15:0]  next_wr_data;

   always_comb begin
      next_state   = state;
      next_bitcnt  = bitcnt;
      next_shreg   = shreg;
      next_dir     = dir;
      next_wphase  = wphase;
      next_reg_ptr = reg_ptr;
      next_hi      = hi;
      next_rd_half = rd_half;
      next_sda_oe  = sda_oe;
      next_wr_stb  = 1'b0;
      next_wr_data = wr_data;
      if (stop_seen) begin
         next_state  = SRSP_D_IDLE;
         next_sda_oe = 1'b0;
      end else if (start_seen) begin
         // A repeated start may arrive in any state and fixes a new direction
         next_state  = SRSP_D_ADDR;
         next_bitcnt = 4'h0;
         next_sda_oe = 1'b0;
         next_wphase = `SRSP_WP_PTR;
      end else if (scl_rise) begin
         unique case (state)
            SRSP_D_ADDR, SRSP_D_WR_BYTE: begin
               next_shreg  = {shreg[6:0], sda_f};
               next_bitcnt = bitcnt + 4'h1;
            end
            SRSP_D_RD_BYTE: begin
               next_bitcnt = bitcnt + 4'h1;
            end
            SRSP_D_RD_ACK: begin
               if (sda_f) begin
                  next_state = SRSP_D_IDLE;
               end else begin
                  // Same register again, lower byte after upper, then upper after lower
                  next_shreg   = rd_half ? rd_data[7:0] : rd_data[15:8];
                  next_rd_half = ~rd_half;
                  next_state   = SRSP_D_RD_LOAD;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (state)
            SRSP_D_ADDR: begin
               if (bitcnt == `SRSP_ACK_CNT) begin
                  if (shreg[7:1] == own_addr) begin
                     next_sda_oe = 1'b1;
                     next_dir    = shreg[0];
                     next_state  = SRSP_D_ADDR_ACK;
                  end else begin
                     next_state = SRSP_D_IDLE;
                  end
               end
            end
            SRSP_D_ADDR_ACK: begin
               next_bitcnt = 4'h0;
               if (dir) begin
                  next_shreg   = rd_data[15:8];
                  next_rd_half = 1'b1;
                  next_sda_oe  = ~rd_data[15];
                  next_state   = SRSP_D_RD_BYTE;
               end else begin
                  next_sda_oe = 1'b0;
                  next_state  = SRSP_D_WR_BYTE;
               end
            end
            SRSP_D_WR_BYTE: begin
               if (bitcnt == `SRSP_ACK_CNT) begin
                  next_sda_oe = 1'b1;
                  next_state  = SRSP_D_WR_ACK;
                  unique case (wphase)
                     `SRSP_WP_PTR: begin
                        next_reg_ptr = shreg;
                        next_wphase  = `SRSP_WP_HI;
                     end
                     `SRSP_WP_HI: begin
                        next_hi     = shreg;
                        next_wphase = `SRSP_WP_LO;
                     end
                     default: begin
                        next_wr_stb  = 1'b1;
                        next_wr_data = {hi, shreg};
                        next_wphase  = `SRSP_WP_PTR;
                     end
                  endcase
               end
            end
            SRSP_D_WR_ACK: begin
               // No burst limit: each ack simply opens the next byte
               next_sda_oe = 1'b0;
               next_bitcnt = 4'h0;
               next_state  = SRSP_D_WR_BYTE;
            end
            SRSP_D_RD_BYTE: begin
               if (bitcnt == `SRSP_ACK_CNT) begin
                  next_sda_oe = 1'b0;
                  next_state  = SRSP_D_RD_ACK;
               end else begin
                  next_shreg  = {shreg[6:0], 1'b0};
                  next_sda_oe = ~shreg[6];
               end
            end
            SRSP_D_RD_LOAD: begin
               next_sda_oe = ~shreg[7];
               next_bitcnt = 4'h0;
               next_state  = SRSP_D_RD_BYTE;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state   <= SRSP_D_IDLE;
         bitcnt  <= 4'h0;
         shreg   <= `SRSP_RST_BYTE;
         dir     <= 1'b0;
         wphase  <= `SRSP_WP_PTR;
         reg_ptr <= `SRSP_RST_BYTE;
         hi      <= `SRSP_RST_BYTE;
         rd_half <= 1'b0;
         sda_oe  <= 1'b0;
         wr_stb  <= 1'b0;
         wr_data <= `SRSP_RST_WORD;
      end else begin
         state   <= next_state;
         bitcnt  <= next_bitcnt;
         shreg   <= next_shreg;
         dir     <= next_dir;
         wphase  <= next_wphase;
         reg_ptr <= next_reg_ptr;
         hi      <= next_hi;
         rd_half <= next_rd_half;
         sda_oe  <= next_sda_oe;
         wr_stb  <= next_wr_stb;
         wr_data <= next_wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drive: only the data line, never the clock

   assign bus.sda_o_d  = 1'b0;
   assign bus.sda_oe_d = sda_oe;

endmodule : srsp_device

// File: srsp_master.sv
// Master end: byte-level two-wire controller that makes the serial clock
`include "srsp_params.svh"

module srsp_master (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // Two-wire bus
   srsp_if.mst                   bus,
   // Command port
   input  wire logic             cmd_valid,
   input  wire srsp_pkg::srsp_kind_t cmd_kind,
   input  wire logic [7:0]       cmd_data,
   input  wire logic             cmd_ack,
   output logic                  cmd_ready,
   // Results
   output logic                  done,
   output logic [7:0]            rx_data,
   output logic                  ack_seen
);
   import srsp_pkg::*;

   localparam logic [6:0] QTR_LAST = 7'(`SRSP_QTR_CYC - 1);

   logic [1:0]   sda_sync;
   srsp_mstate_t state;
   srsp_mstate_t next_state;
   srsp_kind_t   kind;
   srsp_kind_t   next_kind;
   logic [7:0]   txd;
   logic [7:0]   next_txd;
   logic         ackbit;
   logic         next_ackbit;
   logic [3:0]   bitcnt;
   logic [3:0]   next_bitcnt;
   logic [1:0]   qtr;
   logic [1:0]   next_qtr;
   logic [6:0]   cnt;
   logic [6:0]   next_cnt;
   logic         scl_oe;
   logic         next_scl_oe;
   logic         sda_oe;
   logic         next_sda_oe;
   logic         next_cmd_ready;
   logic         next_done;
   logic [7:0]   next_rx_data;
   logic         next_ack_seen;

   ////////////////////////////////////////////////////////////////////////////////
   // Bit engine: four quarters per clock pulse, data moves in quarter one, and start and stop also move it in quarter three

   always_comb begin
      next_state     = state;
      next_kind      = kind;
      next_txd       = txd;
      next_ackbit    = ackbit;
      next_bitcnt    = bitcnt;
      next_qtr       = qtr;
      next_cnt       = cnt;
      next_scl_oe    = scl_oe;
      next_sda_oe    = sda_oe;
      next_cmd_ready = 1'b0;
      next_done      = 1'b0;
      next_rx_data   = rx_data;
      next_ack_seen  = ack_seen;
      unique case (state)
         SRSP_M_IDLE: begin
            next_cmd_ready = 1'b1;
            if (cmd_valid && cmd_ready) begin
               next_kind      = cmd_kind;
               next_txd       = cmd_data;
               next_ackbit    = cmd_ack;
               next_bitcnt    = 4'h0;
               next_qtr       = 2'h0;
               next_cnt       = 7'h00;
               next_cmd_ready = 1'b0;
               next_state     = SRSP_M_RUN;
            end
         end
         SRSP_M_RUN: begin
            if (cnt == 7'h00) begin
               unique case (qtr)
                  2'h0: next_scl_oe = 1'b1;
                  2'h1: begin
                     // Clock is low here, so data may change without a false condition
                     unique case (kind)
                        SRSP_START: next_sda_oe = 1'b0;
                        SRSP_STOP:  next_sda_oe = 1'b1;
                        SRSP_WRITE: next_sda_oe = (bitcnt == `SRSP_ACK_CNT) ? 1'b0 : ~txd[7];
                        SRSP_READ:  next_sda_oe = (bitcnt == `SRSP_ACK_CNT) ? ackbit : 1'b0;
                     endcase
                  end
                  2'h2: next_scl_oe = 1'b0;
                  2'h3: begin
                     if (kind == SRSP_START) begin
                        next_sda_oe = 1'b1;
                     end else if (kind == SRSP_STOP) begin
                        next_sda_oe = 1'b0;
                     end
                  end
               endcase
            end
            if (cnt != QTR_LAST) begin
               next_cnt = cnt + 7'h01;
            end else begin
               next_cnt = 7'h00;
               next_qtr = qtr + 2'h1;
               if (qtr == 2'h3) begin
                  if (kind == SRSP_WRITE || kind == SRSP_READ) begin
                     if (bitcnt == `SRSP_ACK_CNT) begin
                        next_ack_seen = ~sda_sync[1];
                     end else begin
                        next_rx_data = {rx_data[6:0], sda_sync[1]};
                        next_txd     = {txd[6:0], 1'b0};
                     end
                  end
                  if (kind == SRSP_START || kind == SRSP_STOP || bitcnt == `SRSP_ACK_CNT) begin
                     next_done  = 1'b1;
                     next_state = SRSP_M_IDLE;
                  end else begin
                     next_bitcnt = bitcnt + 4'h1;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sda_sync  <= 2'h3;
         state     <= SRSP_M_IDLE;
         kind      <= SRSP_START;
         txd       <= `SRSP_RST_BYTE;
         ackbit    <= 1'b0;
         bitcnt    <= 4'h0;
         qtr       <= 2'h0;
         cnt       <= 7'h00;
         scl_oe    <= 1'b0;
         sda_oe    <= 1'b0;
         cmd_ready <= 1'b0;
         done      <= 1'b0;
         rx_data   <= `SRSP_RST_BYTE;
         ack_seen  <= 1'b0;
      end else begin
         sda_sync  <= {sda_sync[0], bus.sda};
         state     <= next_state;
         kind      <= next_kind;
         txd       <= next_txd;
         ackbit    <= next_ackbit;
         bitcnt    <= next_bitcnt;
         qtr       <= next_qtr;
         cnt       <= next_cnt;
         scl_oe    <= next_scl_oe;
         sda_oe    <= next_sda_oe;
         cmd_ready <= next_cmd_ready;
         done      <= next_done;
         rx_data   <= next_rx_data;
         ack_seen  <= next_ack_seen;
      end
   end

   assign bus.scl_o_m  = 1'b0;
   assign bus.scl_oe_m = scl_oe;
   assign bus.sda_o_m  = 1'b0;
   assign bus.sda_oe_m = sda_oe;

endmodule : srsp_master

// File: srsp_asserts.sv
// Protocol checker watching the two-wire bus between master and device
module srsp_asserts (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rstn,
   // Bus pins
   input  wire logic scl_oe_m,
   input  wire logic sda_oe_d,
   input  wire logic scl,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////
   // Bus position tracking
   logic       prev_scl;
   logic       prev_sda;
   logic       first;
   logic       idle;
   logic       rd;
   logic       nack;
   logic       sel;
   logic [3:0] bits;
   logic       next_first;
   logic       next_idle;
   logic       next_rd;
   logic       next_nack;
   logic       next_sel;
   logic [3:0] next_bits;
   logic       rise;
   logic       start;
   logic       stop;

   always_comb begin
      rise = scl & ~prev_scl;
      start = scl & prev_scl & prev_sda & ~sda;
      stop = scl & prev_scl & ~prev_sda & sda;
      next_bits = bits;
      next_first = first;
      next_idle = idle;
      next_rd = rd;
      next_nack = nack;
      next_sel = sel;
      if (start) begin
         next_bits = 4'h0;
         next_first = 1'b1;
         next_idle = 1'b0;
      end else if (stop) begin
         next_idle = 1'b1;
      end else if (rise) begin
         next_bits = (bits == 4'h9) ? 4'h1 : bits + 4'h1;
         if (bits == 4'h9)
            next_first = 1'b0;
         if (bits == 4'h7 && first)
            next_rd = sda;
         if (bits == 4'h8)
            next_nack = sda;
         if (bits == 4'h8 && first)
            next_sel = ~sda;
      end
   end

   // Bus idles high, so the trackers reset to a released bus
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prev_scl <= 1'b1;
         prev_sda <= 1'b1;
         bits <= 4'h0;
         first <= 1'b0;
         idle <= 1'b1;
         rd <= 1'b0;
         nack <= 1'b1;
         sel <= 1'b0;
      end else begin
         prev_scl <= scl;
         prev_sda <= sda;
         bits <= next_bits;
         first <= next_first;
         idle <= next_idle;
         rd <= next_rd;
         nack <= next_nack;
         sel <= next_sel;
      end
   end

   ////////////////////////////////////////
   // Properties
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_ninth_fall;
      $fell(scl) && bits == 4'h9;
   endsequence
   sequence s_quiet;
      !sda_oe_d [*8];
   endsequence

   property p_no_clk;
      !scl |-> scl_oe_m;
   endproperty
   property p_drv_scl_low;
      $changed(sda_oe_d) |-> !scl;
   endproperty
   property p_addr_quiet;
      (sda_oe_d && first) |-> bits >= 4'h8;
   endproperty
   property p_idle_quiet;
      sda_oe_d |-> !idle;
   endproperty
   property p_wr_release;
      (s_ninth_fall ##0 !rd) |-> ##[1:16] !sda_oe_d;
   endproperty
   property p_nack_release;
      (s_ninth_fall ##0 (rd && !first && nack)) |-> ##[1:16] s_quiet;
   endproperty
   // The first high sample of the next pulse still sees the old bit count, so the
   // slot is only taken once the clock has been high for a full sample
   property p_rd_ack_free;
      (rd && !first && bits == 4'h9 && scl && $past(scl)) |-> !sda_oe_d;
   endproperty
   property p_wr_ack;
      ($rose(scl) && bits == 4'h8 && !first && !rd && sel) |-> sda_oe_d;
   endproperty

   a_no_clk: assert property (p_no_clk)
      else $error("serial clock low without master drive");
   a_drv_scl_low: assert property (p_drv_scl_low)
      else $error("device data changed while clock high");
   a_addr_quiet: assert property (p_addr_quiet)
      else $error("device drove during address bits");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("device drove after stop");
   a_wr_release: assert property (p_wr_release)
      else $error("device held acknowledge past ninth pulse");
   a_nack_release: assert property (p_nack_release)
      else $error("device kept driving after not-acknowledge");
   a_rd_ack_free: assert property (p_rd_ack_free)
      else $error("device drove master acknowledge slot");
   a_wr_ack: assert property (p_wr_ack)
      else $error("selected device missed a write acknowledge");
endmodule : srsp_asserts

// File: tb.sv
// Self-checking bench joining master and device ends over the two-wire bus
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import srsp_pkg::*;

   localparam logic [6:0] ADDR_A = 7'h2C;
   localparam logic [6:0] ADDR_B = 7'h13;

   logic        clock;
   logic        rstn;
   logic        cmd_valid;
   srsp_kind_t  cmd_kind;
   logic [7:0]  cmd_data;
   logic        cmd_ack;
   logic        cmd_ready;
   logic        done;
   logic [7:0]  rx_data;
   logic        ack_seen;
   logic [6:0]  own_addr;
   logic        wr_stb;
   logic [15:0] wr_data;
   logic [7:0]  reg_ptr;
   logic [15:0] rd_data;
   logic [23:0] wlog[$];
   int          err_total;
   int          samples_checked;

   srsp_if bus ();
   srsp_master i_srsp_master (.clock(clock), .rstn(rstn), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
      .cmd_ready(cmd_ready), .done(done), .rx_data(rx_data), .ack_seen(ack_seen));
   srsp_device i_srsp_device (.clock(clock), .rstn(rstn), .bus(bus), .own_addr(own_addr),
      .wr_stb(wr_stb), .wr_data(wr_data), .reg_ptr(reg_ptr), .rd_data(rd_data));
   srsp_asserts i_srsp_asserts (.clock(clock), .rstn(rstn), .scl_oe_m(bus.scl_oe_m),
      .sda_oe_d(bus.sda_oe_d), .scl(bus.scl), .sda(bus.sda));

   ////////////////////////////////////////
   // Clock, register file stand-in, commit log
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Word derived from the pointer so a wrong selection shows in the read data
   always @(posedge clock) rd_data <= {reg_ptr, ~reg_ptr};
   always @(posedge clock) if (wr_stb === 1'b1) wlog.push_back({reg_ptr, wr_data});

   ////////////////////////////////////////
   // Tasks
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_fail();
      err_total++;
      $display("unexpected at %0t: wait timed out", $time);
      finish_test();
   endtask : wait_fail

   // Request held from just after one edge until the edge that samples ready
   task automatic cmd(input srsp_kind_t k, input logic [7:0] d, input logic a);
      int n;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_data <= d;
      cmd_ack <= a;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (cmd_ready !== 1'b1 && n < 50);
      cmd_valid <= 1'b0;
      if (cmd_ready !== 1'b1)
         wait_fail();
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      if (done !== 1'b1)
         wait_fail();
   endtask : cmd

   task automatic wr(input logic [7:0] d, input logic exp);
      cmd(SRSP_WRITE, d, 1'b0);
      check({23'h0, ack_seen}, {23'h0, exp});
   endtask : wr

   task automatic rd(input logic a, input logic [7:0] exp);
      cmd(SRSP_READ, 8'h00, a);
      check({16'h0, rx_data}, {16'h0, exp});
   endtask : rd

   ////////////////////////////////////////
   // Main sequence
   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = SRSP_START;
      cmd_data = 8'h00;
      cmd_ack = 1'b0;
      own_addr = ADDR_A;
      err_total = 0;
      samples_checked = 0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;

      // Two pointer-word groups, then a dangling pointer and upper byte
      cmd(SRSP_START, 8'h00, 1'b0);
      wr({ADDR_A, 1'b0}, 1'b1);
      wr(8'h21, 1'b1);
      wr(8'hA5, 1'b1);
      check(24'(wlog.size()), 24'h00_0000);
      wr(8'h3C, 1'b1);
      wr(8'h2E, 1'b1);
      wr(8'h0F, 1'b1);
      wr(8'hF0, 1'b1);
      wr(8'h44, 1'b1);
      wr(8'h99, 1'b1);
      cmd(SRSP_STOP, 8'h00, 1'b0);
      check(24'(wlog.size()), 24'h00_0002);
      check(wlog[0], 24'h21_A53C);
      check(wlog[1], 24'h2E_0FF0);
      $display("test write groups done");

      // Pointer write, repeated start, two words read back
      cmd(SRSP_START, 8'h00, 1'b0);
      wr({ADDR_A, 1'b0}, 1'b1);
      wr(8'h5A, 1'b1);
      cmd(SRSP_START, 8'h00, 1'b0);
      wr({ADDR_A, 1'b1}, 1'b1);
      rd(1'b1, 8'h5A);
      rd(1'b1, 8'hA5);
      rd(1'b1, 8'h5A);
      rd(1'b0, 8'hA5);
      cmd(SRSP_STOP, 8'h00, 1'b0);
      check(24'(wlog.size()), 24'h00_0002);
      $display("test pointer read done");

      // Old address no longer selects; new one reads the kept pointer
      own_addr <= ADDR_B;
      cmd(SRSP_START, 8'h00, 1'b0);
      wr({ADDR_A, 1'b0}, 1'b0);
      wr(8'h77, 1'b0);
      cmd(SRSP_STOP, 8'h00, 1'b0);
      cmd(SRSP_START, 8'h00, 1'b0);
      wr({ADDR_B, 1'b1}, 1'b1);
      rd(1'b0, 8'h5A);
      cmd(SRSP_STOP, 8'h00, 1'b0);
      check(24'(wlog.size()), 24'h00_0002);
      $display("test address select done");

      finish_test();
   end
endmodule : tb
